// >>> hdl/crs_ctl.sv
// cold redundancy role controller: role register, wake line and converter
// assumes wake_in is an asynchronous pin; faults and share code are on clk

`default_nettype none

module crs_ctl #(
    parameter int unsigned SHARE_W = crs_pkg::SHARE_W,
    parameter int unsigned WAKE_ON_CYCLES = crs_pkg::WAKE_ON_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire crs_pkg::crs_cmd_s cmd,
    output var crs_pkg::crs_rsp_s rsp,
    input wire logic wake_in,
    output var crs_pkg::crs_wake_s wake,
    input wire logic unit_fault,
    input wire logic vout_low,
    input wire logic [SHARE_W-1:0] share_level,
    output var logic converter_on,
    output var logic converter_active_n
);

    typedef struct packed {
        logic wake_meta;
        logic wake_sync;
        logic wake_prev;
        crs_pkg::crs_role_e role;
        logic conv_on;
        logic active_n;
        crs_pkg::crs_wake_s wake;
        crs_pkg::crs_rsp_s rsp;
    } crs_ctl_state_s;

    crs_ctl_state_s st;
    crs_ctl_state_s next_st;

    logic fault;
    logic wake_fall;
    logic standby_role;
    logic ordered_role;
    logic load_awake;
    logic want_active;
    logic role_hit;
    logic [1:0] position;

    assign fault = unit_fault | vout_low;
    assign wake_fall = st.wake_prev & ~st.wake_sync;
    assign ordered_role = st.role inside {crs_pkg::ROLE_STANDBY_1,
        crs_pkg::ROLE_STANDBY_2, crs_pkg::ROLE_STANDBY_3};
    assign standby_role = ordered_role |
        (st.role == crs_pkg::ROLE_PERM_STANDBY);
    assign role_hit = cmd.valid && (cmd.code == crs_pkg::ROLE_CMD_CODE);
    // 02h..04h map to positions 0..2
    assign position = st.role[1:0] - 2'h2;

    crs_share_cmp #(
        .SHARE_W(SHARE_W)
    ) u_share_cmp (
        .clk(clk),
        .reset(reset),
        .share_level(share_level),
        .position(position),
        .track(ordered_role),
        .load_awake(load_awake)
    );

    always_comb begin
        next_st = st;
        next_st.wake_meta = wake_in;
        next_st.wake_sync = st.wake_meta;
        next_st.wake_prev = st.wake_sync;

        // role register access, reads and writes alike answer once
        next_st.rsp = '0;
        if (role_hit) begin
            next_st.rsp.valid = 1'b1;
            next_st.rsp.data = {5'h00, st.role};
            if (cmd.write) begin
                if (cmd.pec_ok && cmd.wdata <= crs_pkg::ROLE_CODE_MAX) begin
                    next_st.role = crs_pkg::crs_role_e'(cmd.wdata[2:0]);
                end else begin
                    next_st.rsp.reject = 1'b1;
                end
            end
        end
        // the hardware drop wins over a write in the same cycle
        if (wake_fall && standby_role) begin
            next_st.role = crs_pkg::ROLE_STANDARD;
        end

        // wake line low means a fault or no always-on driver: all run
        want_active = 1'b1;
        unique case (st.role)
            crs_pkg::ROLE_STANDARD,
            crs_pkg::ROLE_ALWAYS_ON: begin
                want_active = ~st.wake_sync | load_awake;
            end
            crs_pkg::ROLE_STANDBY_1,
            crs_pkg::ROLE_STANDBY_2,
            crs_pkg::ROLE_STANDBY_3: begin
                want_active = ~st.wake_sync | load_awake;
            end
            crs_pkg::ROLE_PERM_STANDBY: begin
                want_active = ~st.wake_sync;
            end
        endcase
        next_st.active_n = ~want_active;
        // standard and always-on roles ignore the active decision
        next_st.conv_on = standby_role ? want_active : 1'b1;

        if (fault) begin
            next_st.wake.out = 1'b0;
            next_st.wake.oe_n = 1'b0;
        end else if (st.role == crs_pkg::ROLE_ALWAYS_ON) begin
            next_st.wake.out = 1'b1;
            next_st.wake.oe_n = 1'b0;
        end else begin
            next_st.wake.out = 1'b0;
            next_st.wake.oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st.wake_meta <= 1'b0;
            st.wake_sync <= 1'b0;
            st.wake_prev <= 1'b0;
            st.role <= crs_pkg::ROLE_RESET;
            st.conv_on <= 1'b1;
            st.active_n <= 1'b0;
            st.wake <= '{out: 1'b0, oe_n: 1'b1};
            st.rsp <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rsp = st.rsp;
    assign wake = st.wake;
    assign converter_on = st.conv_on;
    assign converter_active_n = st.active_n;

    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [31:0] wake_wait;
    always_ff @(posedge clk) begin
        if (reset || wake_in || st.conv_on) begin
            wake_wait <= '0;
        end else begin
            wake_wait <= wake_wait + 32'h1;
        end
    end

    a_fault_pulls_low: assert property (
        fault |=> (!wake.oe_n && !wake.out))
        else $error("fault did not pull the wake line low");

    a_wake_on_bound: assert property (
        wake_wait < WAKE_ON_CYCLES)
        else $error("converter not on in time after wake low");

    a_wake_fall_on: assert property (
        $fell(st.wake_sync) |=> converter_on ##0 !converter_active_n)
        else $error("wake fall did not switch the converter on");

    a_no_driver_on: assert property (
        !st.wake_sync |=> (converter_on && !converter_active_n))
        else $error("converter off with no high driver on wake");

    a_standby_matrix: assert property (
        (ordered_role && st.wake_sync && !load_awake
            && !wake_fall)
        |=> (converter_active_n && !converter_on))
        else $error("standby unit not resting in cold standby");

    a_always_run: assert property (
        !standby_role |=> converter_on)
        else $error("standard role converter switched off");

    a_active_drive: assert property (
        (st.role == crs_pkg::ROLE_ALWAYS_ON && !fault)
        |=> (!wake.oe_n && wake.out))
        else $error("always-on unit not driving wake high");

    a_standard_float: assert property (
        (st.role == crs_pkg::ROLE_STANDARD && !fault) |=> wake.oe_n)
        else $error("standard unit drives wake while healthy");

    a_perm_standby: assert property (
        (st.role == crs_pkg::ROLE_PERM_STANDBY && st.wake_sync)
        |=> (!converter_on && converter_active_n))
        else $error("permanent standby unit switched on");

    a_role_clear: assert property (
        (wake_fall && standby_role)
        |=> st.role == crs_pkg::ROLE_STANDARD)
        else $error("standby role kept after wake fall");

    a_role_write: assert property (
        (role_hit && cmd.write && cmd.pec_ok
            && cmd.wdata <= crs_pkg::ROLE_CODE_MAX
            && !(wake_fall && standby_role))
        |=> (rsp.valid && !rsp.reject
            && {5'h00, st.role} == $past(cmd.wdata)))
        else $error("accepted role write not stored");

    a_bad_write: assert property (
        (role_hit && cmd.write && !cmd.pec_ok
            && !(wake_fall && standby_role))
        |=> (rsp.reject && st.role == $past(st.role)))
        else $error("role write with bad checksum not refused");

    a_range_refuse: assert property (
        (role_hit && cmd.write && cmd.wdata > crs_pkg::ROLE_CODE_MAX
            && !(wake_fall && standby_role))
        |=> (rsp.valid && rsp.reject && st.role == $past(st.role)))
        else $error("out of range role write not refused");

    a_read_answer: assert property (
        (role_hit && !cmd.write)
        |=> (rsp.valid && !rsp.reject
            && rsp.data == {5'h00, $past(st.role)}))
        else $error("role read answer wrong");

    a_other_code: assert property (
        !role_hit |=> !rsp.valid)
        else $error("answer given to a foreign command");

    a_high_bits: assert property (
        rsp.valid |-> rsp.data[7:3] == 5'h00)
        else $error("role read upper bits not zero");

    a_reject_write: assert property (
        rsp.reject |-> (rsp.valid && $past(cmd.write)))
        else $error("reject raised without a write");

    a_role_legal: assert property (
        st.role <= crs_pkg::ROLE_PERM_STANDBY)
        else $error("role register holds an undefined code");

    a_role_steady: assert property (
        (!(role_hit && cmd.write) && !(wake_fall && standby_role))
        |=> $stable(st.role))
        else $error("role changed without write or wake fall");

    // synchroniser and edge detector
    a_sync_delay: assert property (
        $fell(st.wake_meta) |=> !st.wake_sync)
        else $error("wake synchroniser skipped a stage");

    a_fall_detect: assert property (
        $fell(st.wake_sync) |-> wake_fall)
        else $error("wake fall not detected");

    // converter decision and wake drive
    a_standby_awake: assert property (
        (ordered_role && load_awake)
        |=> (converter_on && !converter_active_n))
        else $error("loaded standby unit not active");

    a_active_pair: assert property (
        standby_role |=> (converter_on == !converter_active_n))
        else $error("converter enable and active decision disagree");

    a_perm_low_on: assert property (
        (st.role == crs_pkg::ROLE_PERM_STANDBY && !st.wake_sync)
        |=> converter_on)
        else $error("permanent standby unit off with wake low");

    a_on_follows: assert property (
        (ordered_role && $rose(load_awake)) |=> converter_on)
        else $error("converter not on after share rose past level");

    a_awake_ordered: assert property (
        !ordered_role |=> !load_awake)
        else $error("share tracking active outside ordered roles");

    a_standby_release: assert property (
        (standby_role && !fault) |=> wake.oe_n)
        else $error("healthy standby unit drives the wake line");

    a_std_quiet: assert property (
        (st.role == crs_pkg::ROLE_STANDARD && !fault) |=> !wake.out)
        else $error("healthy standard unit drives wake high");

    a_vout_pull: assert property (
        vout_low |=> (!wake.oe_n && !wake.out))
        else $error("low output did not pull the wake line low");

    c_standby_rest: cover property (
        ordered_role && st.wake_sync ##1 converter_active_n);
    c_load_wake: cover property (
        ordered_role && converter_active_n ##1 !converter_active_n
        && st.wake_sync);
    c_wake_clear: cover property (
        wake_fall && standby_role ##1 st.role == crs_pkg::ROLE_STANDARD);
    c_perm_rest: cover property (
        st.role == crs_pkg::ROLE_PERM_STANDBY ##1 converter_active_n);
    c_fault_drive: cover property (
        fault ##1 (!wake.oe_n && !wake.out));

endmodule // crs_ctl

`default_nettype wire

// >>> hdl/crs_pkg.sv
// constants, role codes and carrier structs for the cold redundancy control
// assumes a 100 MHz unit controller clock and a same-clock share level code
//
// Functional notes
// - fault or low output pulls wake line low
// - standby unit turns on within 100 us
// - no always-on driver high keeps converter on
// - standby needs an always-on unit driving wake high
// - standby only if wake high, share low
// - switch-on level depends on standby position
// - switch-on levels 3.2, 5.0, 6.7 V
// - switch-off levels 1.44, 3.01, 4.52 V
// - 8.0 V share equals full rated power
// - role codes 00h to 05h
// - standard role tri-states wake, low on fault
// - always-on drives high, standby roles tri-state
// - standby codes 02h-04h turn on in order
// - permanent standby ignores share level
// - wake falling edge resets standby role to 00h
// - role register at command D0h with PEC

`default_nettype none

package crs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WAKE_ON_TIME_NS = 100000;
    localparam int unsigned WAKE_ON_CYCLES = WAKE_ON_TIME_NS / CLK_PERIOD_NS;

    localparam logic [7:0] ROLE_CMD_CODE = 8'hD0;
    localparam logic [7:0] ROLE_CODE_MAX = 8'h05;
    localparam int unsigned STANDBY_POSITIONS = 3;

    typedef enum logic [2:0] {
        ROLE_STANDARD = 3'b000,
        ROLE_ALWAYS_ON = 3'b001,
        ROLE_STANDBY_1 = 3'b010,
        ROLE_STANDBY_2 = 3'b011,
        ROLE_STANDBY_3 = 3'b100,
        ROLE_PERM_STANDBY = 3'b101
    } crs_role_e;

    localparam crs_role_e ROLE_RESET = ROLE_STANDARD;

    // share code scale: full code stands for 8.0 V, full rated power
    localparam int unsigned SHARE_W = 12;
    localparam int unsigned SHARE_CODE_MAX = 4095;
    localparam int unsigned SHARE_FULL_MV = 8000;
    localparam int unsigned SHARE_ON_MV_1 = 3200;
    localparam int unsigned SHARE_ON_MV_2 = 5000;
    localparam int unsigned SHARE_ON_MV_3 = 6700;
    localparam int unsigned SHARE_OFF_MV_1 = 1440;
    localparam int unsigned SHARE_OFF_MV_2 = 3010;
    localparam int unsigned SHARE_OFF_MV_3 = 4520;

    localparam logic [2:0][11:0] SHARE_ON_CODE = {
        12'(SHARE_ON_MV_3 * SHARE_CODE_MAX / SHARE_FULL_MV),
        12'(SHARE_ON_MV_2 * SHARE_CODE_MAX / SHARE_FULL_MV),
        12'(SHARE_ON_MV_1 * SHARE_CODE_MAX / SHARE_FULL_MV)
    };
    localparam logic [2:0][11:0] SHARE_OFF_CODE = {
        12'(SHARE_OFF_MV_3 * SHARE_CODE_MAX / SHARE_FULL_MV),
        12'(SHARE_OFF_MV_2 * SHARE_CODE_MAX / SHARE_FULL_MV),
        12'(SHARE_OFF_MV_1 * SHARE_CODE_MAX / SHARE_FULL_MV)
    };

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic write;
        logic [7:0] wdata;
        logic pec_ok;
    } crs_cmd_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic reject;
    } crs_rsp_s;

    typedef struct packed {
        logic out;
        logic oe_n;
    } crs_wake_s;

endpackage

`default_nettype wire

// >>> hdl/crs_share_cmp.sv
// load share comparator with per-position switch-on and switch-off levels
// assumes the share code is produced on the same clock as this module

`default_nettype none

module crs_share_cmp #(
    parameter int unsigned SHARE_W = crs_pkg::SHARE_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [SHARE_W-1:0] share_level,
    input wire logic [1:0] position,
    input wire logic track,
    output var logic load_awake
);

    typedef struct packed {
        logic awake;
    } crs_cmp_state_s;

    crs_cmp_state_s st;
    crs_cmp_state_s next_st;
    logic [crs_pkg::STANDBY_POSITIONS-1:0] above_on;
    logic [crs_pkg::STANDBY_POSITIONS-1:0] below_off;

    genvar i;
    generate
        for (i = 0; i < crs_pkg::STANDBY_POSITIONS; i++) begin : g_pos
            // each position has its own pair of levels
            assign above_on[i] =
                share_level > SHARE_W'(crs_pkg::SHARE_ON_CODE[i]);
            assign below_off[i] =
                share_level < SHARE_W'(crs_pkg::SHARE_OFF_CODE[i]);
        end
    endgenerate

    always_comb begin
        next_st = st;
        if (!track) begin
            next_st.awake = 1'b0;
        end else if (above_on[position]) begin
            next_st.awake = 1'b1;
        end else if (below_off[position]) begin
            next_st.awake = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign load_awake = st.awake;

    a_hold_band: assert property (@(posedge clk) disable iff (reset)
        (track && st.awake && !below_off[position]) |=> st.awake)
        else $error("share hysteresis dropped inside band");

endmodule // crs_share_cmp

`default_nettype wire

// >>> verification/crs_peer_model.sv
// peer supplies on the shared wake line, resolved with the unit's own drive
// assumes a weak pull-down on the line: a released line reads low
`default_nettype none

module crs_peer_model (
    input wire logic peer_high,
    input wire logic peer_fault,
    input wire crs_pkg::crs_wake_s dut_wake,
    output var logic level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pull_low;
    logic drive_high;

    // any faulty party pulls low and wins over every high driver
    assign pull_low = peer_fault || (!dut_wake.oe_n && !dut_wake.out);
    // a healthy always-on party drives high
    assign drive_high = peer_high || (!dut_wake.oe_n && dut_wake.out);
    assign level = !pull_low && drive_high;
endmodule // crs_peer_model

`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the cold redundancy controller
// assumes crs_ctl with a peer model resolving the shared wake line
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WAKE_MAX = 50;
    logic clk;
    logic reset;
    crs_pkg::crs_cmd_s cmd;
    crs_pkg::crs_rsp_s rsp;
    crs_pkg::crs_wake_s wake;
    logic wake_in, unit_fault, vout_low, converter_on, converter_active_n;
    logic peer_high, peer_fault;
    logic [11:0] share_level, on, off;
    logic [31:0] seed;
    int n_errors, comparisons, n;
    int cycles = 0;
    int unsigned on_mv[3] = '{crs_pkg::SHARE_ON_MV_1,
        crs_pkg::SHARE_ON_MV_2, crs_pkg::SHARE_ON_MV_3};
    int unsigned off_mv[3] = '{crs_pkg::SHARE_OFF_MV_1,
        crs_pkg::SHARE_OFF_MV_2, crs_pkg::SHARE_OFF_MV_3};
    int kind[7] = '{0, 1, 2, 3, 4, 5, 3};
    logic exp_on[7] = '{0, 0, 1, 1, 1, 0, 0};

    crs_ctl #(.WAKE_ON_CYCLES(WAKE_MAX)) dut (.clk(clk), .reset(reset),
        .cmd(cmd), .rsp(rsp), .wake_in(wake_in), .wake(wake),
        .unit_fault(unit_fault), .vout_low(vout_low),
        .share_level(share_level), .converter_on(converter_on),
        .converter_active_n(converter_active_n));
    crs_peer_model peer (.peer_high(peer_high), .peer_fault(peer_fault),
        .dut_wake(wake), .level(wake_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] lvl(int unsigned mv);
        return 12'(mv * crs_pkg::SHARE_CODE_MAX / crs_pkg::SHARE_FULL_MV);
    endfunction

    // share levels: below off, at on, just above on, hold band, at off
    function automatic logic [11:0] pick(int k);
        case (k)
            0: return 12'(xs() % off);
            1: return on;
            2: return on + 12'h001;
            3: return 12'(off + xs() % (on - off + 1));
            4: return off;
            default: return off - 12'h001;
        endcase
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic req(input logic w, input logic [7:0] code,
        input logic [7:0] d, input logic pec);
        @(posedge clk);
        cmd <= '{valid: 1'b1, code: code, write: w, wdata: d, pec_ok: pec};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1;
    endtask

    task automatic setr(input logic [7:0] r);
        req(1'b1, 8'hD0, r, 1'b1);
        chk({rsp.valid, rsp.reject}, 8'h02);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic end_sim();
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        seed = 38;
        cmd = '0;
        reset = 1'b1;
        // a peer holds the wake line high, so role writes cause no fall
        {unit_fault, vout_low, peer_high, peer_fault} = 4'h2;
        share_level = 12'h000;
        n_errors = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({converter_on, converter_active_n, wake.oe_n}, 8'h05);
        for (int r = 0; r < 6; r++) begin
            setr(8'(r));
            req(1'b0, 8'hD0, 8'h00, 1'b0);
            chk(rsp.data, 8'(r));
        end
        req(1'b1, 8'hD0, 8'h06, 1'b1);
        chk({rsp.valid, rsp.reject}, 8'h03);
        req(1'b1, 8'hD0, 8'h02, 1'b0);
        chk({rsp.valid, rsp.reject}, 8'h03);
        req(1'b1, 8'hD1, 8'h02, 1'b1);
        chk(rsp.valid, 8'h00);
        req(1'b0, 8'hD0, 8'h00, 1'b1);
        chk(rsp.data, 8'h05);
        @(posedge clk);
        share_level <= 12'h000;
        peer_high <= 1'b0;
        settle();
        chk(converter_on, 8'h01);
        req(1'b0, 8'hD0, 8'h00, 1'b1);
        chk(rsp.data, 8'h00);
        @(posedge clk);
        peer_high <= 1'b1;
        share_level <= 12'hFFF;
        settle();
        setr(8'h05);
        settle();
        chk({converter_on, converter_active_n}, 8'h01);
        for (int r = 0; r < 2; r++) begin
            setr(8'(r));
            settle();
            chk(converter_on, 8'h01);
            chk(wake.oe_n, 8'(r == 0));
            if (r == 1) chk(wake.out, 8'h01);
            for (int f = 0; f < 3; f++) begin
                @(posedge clk);
                unit_fault <= (f == 0);
                vout_low <= (f == 1);
                settle();
                if (f < 2) chk({wake.oe_n, wake.out}, 8'h00);
            end
        end
        for (int p = 0; p < 3; p++) begin
            on = lvl(on_mv[p]);
            off = lvl(off_mv[p]);
            setr(8'(p + 2));
            for (int s = 0; s < 7; s++) begin
                @(posedge clk);
                share_level <= pick(kind[s]);
                settle();
                chk(converter_on, 8'(exp_on[s]));
                chk(converter_active_n, 8'(!exp_on[s]));
            end
            @(posedge clk);
            peer_fault <= (p == 1);
            peer_high <= (p == 1);
            n = 0;
            while (converter_on !== 1'b1 && n < WAKE_MAX) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(converter_on, 8'h01);
            req(1'b0, 8'hD0, 8'h00, 1'b1);
            chk(rsp.data, 8'h00);
            @(posedge clk);
            peer_fault <= 1'b0;
            peer_high <= 1'b1;
            settle();
        end
        end_sim();
    end
endmodule // testbench

`default_nettype wire
